// *** rtl/pmd_module_disable_unit.sv ***
// module disable unit: per-peripheral clock, reset, register and output gating
`include "pmd_map.svh"

module mdu_module_disable_unit (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ctrl_wr_i,
  input wire logic [`MDU_DATA_W-1:0] ctrl_data_i,
  input wire logic [`MDU_NUM_MODULES-1:0] module_disable_i,
  input wire logic [`MDU_NUM_MODULES-1:0] alt_clk_i,
  input wire mdu_pkg::mdu_port_s [`MDU_NUM_MODULES-1:0] cpu_side_i,
  input wire mdu_pkg::mdu_port_s [`MDU_NUM_MODULES-1:0] periph_side_i,
  input wire logic [`MDU_NUM_MODULES-1:0] analog_en_i,
  output logic [`MDU_NUM_MODULES-1:0] module_clk_o,
  output logic [`MDU_NUM_MODULES-1:0] module_rst_o,
  output logic [`MDU_NUM_MODULES-1:0] module_active_o,
  output logic [`MDU_NUM_MODULES-1:0] analog_en_o,
  output logic [`MDU_NUM_MODULES-1:0] wr_en_o,
  output logic [`MDU_NUM_MODULES*`MDU_DATA_W-1:0] wr_data_o,
  output logic [`MDU_NUM_MODULES*`MDU_DATA_W-1:0] rd_data_o,
  output logic [`MDU_NUM_MODULES*`MDU_DATA_W-1:0] dout_o,
  output logic peripheral_clock_gate_o
);

  // ****************************************
  // control registers
  // ****************************************
  logic gate_reg;
  logic gate_next;
  mdu_pkg::mdu_mask_t dis_reg;
  mdu_pkg::mdu_mask_t dis_next;

  always_comb
  begin
    gate_next = gate_reg;
    dis_next = module_disable_i;
    if (ctrl_wr_i)
    begin
      gate_next = ctrl_data_i[`MDU_CLK_GATE_BIT];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gate_reg <= `MDU_GATE_RESET;
      dis_reg <= `MDU_CTRL_RESET;
    end
    else
    begin
      gate_reg <= gate_next;
      dis_reg <= dis_next;
    end
  end

  assign peripheral_clock_gate_o = gate_reg;

  // ****************************************
  // per-module gating
  // ****************************************
  localparam mdu_pkg::mdu_mask_t SYS_USERS = `MDU_SYS_CLOCK_USERS;

  genvar g;
  generate
    for (g = 0; g < `MDU_NUM_MODULES; g++)
    begin : g_mod
      logic clk_src;
      logic clk_en_reg;
      logic clk_en_next;
      logic clk_en_lat;
      logic [3:0] wake_reg;
      logic [3:0] wake_next;
      mdu_pkg::mdu_state_e st_reg;
      mdu_pkg::mdu_state_e st_next;

      // only system clock users see the gate
      assign clk_src = SYS_USERS[g] ? mclk_i : alt_clk_i[g];

      always_comb
      begin
        st_next = st_reg;
        wake_next = wake_reg;
        // gate stops system clock to users
        clk_en_next = !dis_reg[g] && !(gate_reg && SYS_USERS[g]);
        unique case (st_reg)
          mdu_pkg::MDU_ON:
          begin
            if (dis_reg[g])
            begin
              st_next = mdu_pkg::MDU_OFF;
            end
          end
          mdu_pkg::MDU_OFF:
          begin
            if (!dis_reg[g])
            begin
              st_next = mdu_pkg::MDU_WAKE;
              wake_next = `MDU_WAKE_CYCLES;
            end
          end
          mdu_pkg::MDU_WAKE:
          begin
            if (dis_reg[g])
            begin
              st_next = mdu_pkg::MDU_OFF;
            end
            else if (wake_reg <= 4'h1)
            begin
              st_next = mdu_pkg::MDU_ON;
            end
            else
            begin
              wake_next = wake_reg - 4'h1;
            end
          end
          default:
          begin
            // unused code recovers through the wake sequence
            st_next = mdu_pkg::MDU_OFF;
          end
        endcase
      end

      always_ff @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          st_reg <= mdu_pkg::MDU_ON;
          wake_reg <= 4'h0;
          clk_en_reg <= 1'b1;
        end
        else
        begin
          st_reg <= st_next;
          wake_reg <= wake_next;
          clk_en_reg <= clk_en_next;
        end
      end

      // enable latched while clock low, glitch-free gate
      always_latch
      begin
        if (!clk_src)
        begin
          clk_en_lat <= clk_en_reg;
        end
      end
      assign module_clk_o[g] = clk_src && clk_en_lat;
      // release from reset gives power-on values
      assign module_rst_o[g] = reset_i || dis_reg[g];
      assign module_active_o[g] = (st_reg == mdu_pkg::MDU_ON);
      assign wr_en_o[g] = cpu_side_i[g].wr_en && !dis_reg[g];
      assign wr_data_o[g*`MDU_DATA_W +: `MDU_DATA_W] = cpu_side_i[g].wr_data;
      assign rd_data_o[g*`MDU_DATA_W +: `MDU_DATA_W] =
        dis_reg[g] ? `MDU_READ_ZERO : periph_side_i[g].rd_data;
      assign dout_o[g*`MDU_DATA_W +: `MDU_DATA_W] =
        dis_reg[g] ? `MDU_READ_ZERO : periph_side_i[g].dout;
      assign analog_en_o[g] = analog_en_i[g] && !dis_reg[g];

      // ****************************************
      // checks
      // ****************************************
      a_rst_held: assert property (@(posedge mclk_i) disable iff (reset_i)
        dis_reg[g] |-> module_rst_o[g]) else $error("reset not held");
      a_read_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
        dis_reg[g] |-> rd_data_o[g*`MDU_DATA_W +: `MDU_DATA_W] == 8'h00
        && !wr_en_o[g]) else $error("disabled access leaked");
      a_out_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
        dis_reg[g] |-> dout_o[g*`MDU_DATA_W +: `MDU_DATA_W] == 8'h00
        && !analog_en_o[g]) else $error("outputs not forced");
      a_clk_off: assert property (@(posedge mclk_i) disable iff (reset_i)
        dis_reg[g] |=> !clk_en_reg) else $error("clock not stopped");
      a_wake_time: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(dis_reg[g]) ##0 !dis_reg[g] [*6] |-> module_active_o[g])
        else $error("module not active in time");
      a_release: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(dis_reg[g]) |-> !module_rst_o[g] && !module_active_o[g])
        else $error("reset not released or woke too early");
      c_disable: cover property (@(posedge mclk_i) disable iff (reset_i)
        $rose(dis_reg[g]));
      c_wake: cover property (@(posedge mclk_i) disable iff (reset_i)
        $rose(module_active_o[g]));
    end
  endgenerate

  a_gate_stop: assert property (@(posedge mclk_i) disable iff (reset_i)
    gate_reg |=> !g_mod[0].clk_en_reg) else $error("system clock not gated");
  a_alt_runs: assert property (@(posedge mclk_i) disable iff (reset_i)
    gate_reg && !dis_reg[7] |=> g_mod[7].clk_en_reg) else $error("alt clock gated");
  a_reset_on: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> dis_reg == 8'h00 && !gate_reg) else $error("reset state wrong");
  c_gate: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(gate_reg));

endmodule : mdu_module_disable_unit

// *** rtl/pmd_map.svh ***
// constants for the module disable unit
`ifndef MDU_MAP_SVH
`define MDU_MAP_SVH
`define MDU_NUM_MODULES 8
`define MDU_DATA_W 8
`define MDU_CTRL_RESET 8'h00
`define MDU_GATE_RESET 1'b0
`define MDU_CLK_GATE_BIT 7
`define MDU_READ_ZERO 8'h00
`define MDU_SYS_CLOCK_USERS 8'h7F
`define MDU_WAKE_CYCLES 4'h4
`endif

// *** rtl/pmd_pkg.sv ***
// types for the module disable unit
`include "pmd_map.svh"
package mdu_pkg;
  typedef logic [`MDU_NUM_MODULES-1:0] mdu_mask_t;
  typedef struct packed {
    logic wr_en;
    logic [`MDU_DATA_W-1:0] wr_data;
    logic [`MDU_DATA_W-1:0] rd_data;
    logic [`MDU_DATA_W-1:0] dout;
  } mdu_port_s;
  typedef enum logic [1:0] {MDU_ON, MDU_OFF, MDU_WAKE} mdu_state_e;
endpackage : mdu_pkg

// *** testbench/pmd_periph_model.sv ***
// behavioural peripheral modules behind the disable unit
module mdu_periph_model (
  input wire logic [7:0] clk_i,
  input wire logic [7:0] rst_i,
  output mdu_pkg::mdu_port_s [7:0] side_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // per-module counters
  // ****
  for (genvar g = 0; g < 8; g++)
  begin : g_mod
    logic [7:0] cnt_reg;
    always_ff @(posedge clk_i[g] or posedge rst_i[g])
    begin
      if (rst_i[g])
        cnt_reg <= 8'h00;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
    assign side_o[g] = '{1'b0, 8'h00, cnt_reg, ~cnt_reg};
  end
endmodule : mdu_periph_model

// *** testbench/tb_top.sv ***
// self-checking bench for the module disable unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ctrl_wr_i = 1'b0;
  logic [7:0] ctrl_data_i = 8'h00;
  logic [7:0] dis = 8'h00;
  logic [7:0] alt = 8'h00;
  logic [7:0] ana = 8'hFF;
  mdu_pkg::mdu_port_s [7:0] cpu;
  mdu_pkg::mdu_port_s [7:0] per;
  logic [7:0] mclk, mrst, act, ana_o, wen;
  logic [63:0] wd, rd, dq;
  logic gate;
  int failures = 0;
  int compares = 0;
  int e [8] = '{default: 0};
  int s [8];
  // ****
  // clocks, instances
  // ****
  initial
    forever #10 mclk_i = ~mclk_i;
  initial
    forever #7 alt[7] = ~alt[7];
  for (genvar g = 0; g < 8; g++)
  begin : g_cnt
    always @(posedge mclk[g]) e[g]++;
  end
  mdu_module_disable_unit u_mdu_module_disable_unit (.mclk_i(mclk_i), .reset_i(reset_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_data_i(ctrl_data_i), .module_disable_i(dis),
    .alt_clk_i(alt), .cpu_side_i(cpu), .periph_side_i(per), .analog_en_i(ana),
    .module_clk_o(mclk), .module_rst_o(mrst), .module_active_o(act),
    .analog_en_o(ana_o), .wr_en_o(wen), .wr_data_o(wd), .rd_data_o(rd),
    .dout_o(dq), .peripheral_clock_gate_o(gate));
  mdu_periph_model u_mdu_periph_model (.clk_i(mclk), .rst_i(mrst), .side_o(per));
  task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  task automatic t_reset();
    for (int g = 0; g < 8; g++)
      cpu[g] = '{1'b1, 8'h3C, 8'h00, 8'h00};
    cyc(5);
    chk("rst", mrst, 8'hFF);
    reset_i = 1'b0;
    cyc(2);
    chk("act", act, 8'hFF);
    chk("gate", gate, 0);
    chk("wd", wd[7:0], 8'h3C);
    $display("reset done");
  endtask : t_reset
  task automatic t_disable();
    dis = 8'h01;
    cyc(3);
    chk("rst", mrst, 8'h01);
    chk("rd", rd[7:0], 8'h00);
    chk("wen", wen, 8'hFE);
    chk("dout", dq[7:0], 8'h00);
    chk("ana", ana_o, 8'hFE);
    chk("rd1", rd[15:8], per[1].rd_data);
    chk("dout1", dq[15:8], per[1].dout);
    s = e;
    cyc(10);
    chk("clk0", e[0] - s[0], 0);
    chk("clk1", e[1] - s[1], 10);
    $display("disable done");
  endtask : t_disable
  task automatic t_enable();
    int n;
    // no writes until the module is active
    cpu[0].wr_en = 1'b0;
    dis = 8'h00;
    for (n = 0; n < 9 && act[0] !== 1'b1; n++)
      cyc(1);
    chk("wake", n < 9, 1);
    cpu[0].wr_en = 1'b1;
    cyc(1);
    chk("rst", mrst, 8'h00);
    chk("wen", wen, 8'hFF);
    chk("cnt", rd[7:0] < 8'h10, 1);
    $display("enable done");
  endtask : t_enable
  task automatic t_gate();
    ctrl_data_i = 8'h80;
    ctrl_wr_i = 1'b1;
    cyc(1);
    ctrl_wr_i = 1'b0;
    cyc(1);
    chk("gate", gate, 1);
    cyc(3);
    s = e;
    cyc(10);
    for (int g = 0; g < 7; g++)
      chk("sys", e[g] - s[g], 0);
    chk("alt", e[7] - s[7] > 0, 1);
    ctrl_data_i = 8'h7F;
    ctrl_wr_i = 1'b1;
    cyc(1);
    ctrl_wr_i = 1'b0;
    s = e;
    cyc(4);
    chk("gate", gate, 0);
    chk("resume", e[0] - s[0] > 0, 1);
    $display("gate done");
  endtask : t_gate
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    t_reset();
    t_disable();
    t_enable();
    t_gate();
    tally_and_finish();
  end
endmodule : tb_top
